// ---- design/lintc_channel.sv ----
`timescale 1ns/1ps
`include "lintc_consts.svh"
module lintc_channel #(
  parameter int TXDOM_CYC = `LINTC_TXDOM_CYC
) (
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    txData,
  output logic                         rxData,
  input  wire logic                    busIn,
  output logic                         busOut,
  output logic                         busOe_n,
  input  wire lintc_pkg::lintc_cmd_type cmd,
  input  wire logic                    chipNormal,
  input  wire logic                    supplyLow,
  input  wire logic                    overTemp,
  input  wire logic                    lpRegOn,
  input  wire logic                    lpRegOff,
  output lintc_pkg::lintc_stat_type    stat,
  output logic                         weakPullupEn,
  output logic                         normPullupEn,
  output logic                         highSideEn,
  output logic [1:0]                   slopeSel,
  output logic                         wakeEvent,
  output logic                         wakeIrq,
  output logic                         regRestart
);
  import lintc_pkg::*;
  // =====================================================
  // control state
  logic [1:0]             mode_q;
  logic [1:0]             baud_q;
  logic                   wakeEn_q;
  logic                   toFlag_q;
  logic                   wakeFlag_q;
  logic [`LINTC_CNT_W-1:0] domCnt_q;
  logic [`LINTC_CNT_W-1:0] wakeCnt_q;
  lintc_wake_type         wk_q;
  logic                   active;
  logic                   txAllowed;
  logic                   fifoBus;
  logic                   fifoValid;
  logic                   wakeHit;

  function automatic logic isMode(input logic [1:0] m, input logic [1:0] code);
    return m == code;
  endfunction

  assign active = chipNormal && !overTemp;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_q   <= `LINTC_MODE_DIS;
      baud_q   <= `LINTC_BAUD_20K;
      wakeEn_q <= 1'b0;
    end else if (cmd.cmdValid) begin
      baud_q   <= cmd.cmdBaud;
      wakeEn_q <= cmd.cmdWakeEn;
      // tx/rx refused while tx held low
      if (!(isMode(cmd.cmdMode, `LINTC_MODE_TXRX) && !txData)) begin
        mode_q <= cmd.cmdMode;
      end
    end
  end

  // =====================================================
  // dominant timeout
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      domCnt_q <= '0;
      toFlag_q <= 1'b0;
    end else if (txData || !isMode(mode_q, `LINTC_MODE_TXRX)) begin
      domCnt_q <= '0;
      toFlag_q <= 1'b0;
    end else if (domCnt_q >= `LINTC_CNT_W'(TXDOM_CYC)) begin
      toFlag_q <= 1'b1;
    end else begin
      domCnt_q <= domCnt_q + `LINTC_CNT_W'(1);
    end
  end

  assign txAllowed = active && isMode(mode_q, `LINTC_MODE_TXRX) && !toFlag_q && !supplyLow;

  // received samples buffered; one cycle of slack keeps rx aligned
  lintc_fifo #(.WIDTH(`LINTC_FIFO_W), .DEPTH(`LINTC_FIFO_D), .AW(`LINTC_FIFO_AW)) uRxFifo (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .inData   (busIn),
    .inValid  (1'b1),
    .inReady  (),
    .outData  (fifoBus),
    .outValid (fifoValid),
    .outReady (1'b1)
  );

  // =====================================================
  // pins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busOut       <= 1'b0;
      busOe_n      <= 1'b1;
      rxData       <= 1'b1;
      highSideEn   <= 1'b0;
      weakPullupEn <= 1'b1;
      normPullupEn <= 1'b0;
      slopeSel     <= `LINTC_BAUD_20K;
    end else begin
      busOut       <= 1'b0;
      busOe_n      <= !(txAllowed && !txData);
      rxData       <= (active && isMode(mode_q, `LINTC_MODE_TXRX) && fifoValid) ? fifoBus : 1'b1;
      highSideEn   <= active;
      weakPullupEn <= !active || isMode(mode_q, `LINTC_MODE_SLEEP);
      normPullupEn <= active && !isMode(mode_q, `LINTC_MODE_SLEEP);
      slopeSel     <= baud_q;
    end
  end

  // =====================================================
  // wake detection
  always_ff @(posedge clk_sys) begin
    if (srst || !wakeEn_q || !isMode(mode_q, `LINTC_MODE_SLEEP)) begin
      wk_q      <= WK_IDLE;
      wakeCnt_q <= '0;
    end else begin
      unique case (wk_q)
        WK_IDLE: begin
          wakeCnt_q <= '0;
          if (busIn) wk_q <= WK_LOW;
        end
        WK_LOW: begin
          if (busIn) begin
            wk_q <= WK_LOW;
            wakeCnt_q <= '0;
          end else begin
            wakeCnt_q <= wakeCnt_q + `LINTC_CNT_W'(1);
            if (wakeCnt_q >= `LINTC_CNT_W'(`LINTC_WAKE_CYC)) wk_q <= WK_QUAL;
          end
        end
        WK_QUAL: begin
          if (busIn) wk_q <= WK_IDLE;
        end
        // unused code falls back to idle rather than sticking
        default: begin
          wk_q <= WK_IDLE;
        end
      endcase
    end
  end

  assign wakeHit = (wk_q == WK_QUAL) && busIn;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wakeEvent  <= 1'b0;
      wakeIrq    <= 1'b0;
      regRestart <= 1'b0;
      wakeFlag_q <= 1'b0;
    end else begin
      wakeEvent  <= wakeHit;
      wakeIrq    <= wakeHit && lpRegOn;
      regRestart <= wakeHit && lpRegOff;
      if (wakeHit) wakeFlag_q <= 1'b1;
      else if (cmd.cmdValid) wakeFlag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat <= '0;
    end else begin
      stat <= '{timeoutFlag: toFlag_q, wakeFlag: wakeFlag_q || wakeHit, modeNow: mode_q, baudNow: baud_q};
    end
  end
endmodule // lintc_channel

// ---- shared/lintc_consts.svh ----
`ifndef LINTC_CONSTS_SVH
`define LINTC_CONSTS_SVH
// Operation
// - tx low drives bus dominant, high releases
// - receive output mirrors bus level in tx/rx mode; high otherwise
// - long dominant tx forces recessive, sets flag
// - timeout in tx/rx mode; recovers when tx high
// - supply undervoltage holds bus recessive
// - overtemperature disables driver, receiver, high-side switch
// - software selects 20k, 10k or fast slope
// - interface active only in chip normal mode
// - modes transmit/receive and disable supported
// - tx/rx command accepted only while tx high
// - sleep disables tx, weak pull-up, monitors bus
// - wake needs fall, dominant over 70us, rise
// - wake reported; interrupt or regulator restart
// - wake detection enabled by software setting
// =====================================================
// timing
`define LINTC_CLK_MHZ        125
`define LINTC_WAKE_US        70
`define LINTC_WAKE_CYC       (`LINTC_WAKE_US * `LINTC_CLK_MHZ + 1)
`define LINTC_TXDOM_US       6000
`define LINTC_TXDOM_CYC      (`LINTC_TXDOM_US * `LINTC_CLK_MHZ)
`define LINTC_CNT_W          20
// =====================================================
// encodings
`define LINTC_MODE_DIS       2'h0
`define LINTC_MODE_TXRX      2'h1
`define LINTC_MODE_SLEEP     2'h2
`define LINTC_BAUD_20K       2'h0
`define LINTC_BAUD_10K       2'h1
`define LINTC_BAUD_FAST      2'h2
`define LINTC_FIFO_W         1
`define LINTC_FIFO_D         8
`define LINTC_FIFO_AW        3
`endif

// ---- shared/lintc_pkg.sv ----
package lintc_pkg;
  typedef struct packed {
    logic       cmdValid;
    logic [1:0] cmdMode;
    logic [1:0] cmdBaud;
    logic       cmdWakeEn;
  } lintc_cmd_type;
  typedef struct packed {
    logic       timeoutFlag;
    logic       wakeFlag;
    logic [1:0] modeNow;
    logic [1:0] baudNow;
  } lintc_stat_type;
  typedef enum logic [1:0] {
    WK_IDLE = 2'h0,
    WK_LOW  = 2'h1,
    WK_QUAL = 2'h3
  } lintc_wake_type;
endpackage

// ---- design/lintc_fifo.sv ----
`timescale 1ns/1ps
`include "lintc_consts.svh"
module lintc_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady = (count_q != (AW+1)'(DEPTH)) || (outReady && outValid);
  assign push    = inValid && inReady;
  assign pop     = outValid && outReady;
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + AW'(1);
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + AW'(1);
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // lintc_fifo

// ---- testbench/lintc_bus_model.sv ----
`timescale 1ns/1ps
module lintc_bus_model (
  input  wire logic busOut,
  input  wire logic busOe_n,
  input  wire logic domReq,
  output logic      busIn
);
  // the pull-up restores recessive once all parties let go
  assign busIn = !((!busOe_n && !busOut) || domReq);
endmodule // lintc_bus_model

// ---- testbench/lintc_channel_checker.sv ----
`timescale 1ns/1ps
module lintc_channel_checker #(
  parameter int TXDOM_CYC = 50
) (
  input wire logic                     clk_sys,
  input wire logic                     srst,
  input wire logic                     txData,
  input wire logic                     busIn,
  input wire logic                     busOe_n,
  input wire lintc_pkg::lintc_cmd_type  cmd,
  input wire logic                     chipNormal,
  input wire logic                     supplyLow,
  input wire logic                     overTemp,
  input wire lintc_pkg::lintc_stat_type stat,
  input wire logic                     weakPullupEn,
  input wire logic                     normPullupEn,
  input wire logic                     highSideEn,
  input wire logic                     wakeEvent
);
  import lintc_pkg::*;
  int lowCnt;
  always_ff @(posedge clk_sys) begin
    lowCnt <= (srst || txData) ? 0 : lowCnt + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence refuse_s;
    // idle cycle first so the registered mode has caught up with the command
    !cmd.cmdValid ##1 (cmd.cmdValid && cmd.cmdMode == 2'h1 && !txData && stat.modeNow != 2'h1);
  endsequence
  sequence asleep_s;
    (stat.modeNow == 2'h2) [*2];
  endsequence
  tx_release_a: assert property (txData |=> busOe_n) else $error("bus driven with tx high");
  supply_hold_a: assert property (supplyLow |=> busOe_n) else $error("bus driven in undervoltage");
  thermal_off_a: assert property (overTemp |=> busOe_n && !highSideEn) else $error("hot but active");
  inactive_bus_a: assert property (!chipNormal |=> busOe_n) else $error("bus driven outside normal");
  dom_timeout_a: assert property (lowCnt > TXDOM_CYC + 2 && stat.modeNow == 2'h1 |-> busOe_n)
    else $error("dominant timeout missed");
  txrx_refuse_a: assert property (refuse_s |=> (stat.modeNow != 2'h1) [*2]) else $error("refused mode taken");
  sleep_pullup_a: assert property (asleep_s |-> busOe_n && weakPullupEn && !normPullupEn)
    else $error("sleep pull-up wrong");
  wake_edge_a: assert property (wakeEvent |-> $past(busIn) && !$past(busIn, 2)) else $error("wake without edge");
endmodule // lintc_channel_checker
bind lintc_channel lintc_channel_checker #(.TXDOM_CYC(TXDOM_CYC)) u_lintc_channel_checker (
  .clk_sys(clk_sys), .srst(srst), .txData(txData), .busIn(busIn), .busOe_n(busOe_n), .cmd(cmd),
  .chipNormal(chipNormal), .supplyLow(supplyLow), .overTemp(overTemp), .stat(stat),
  .weakPullupEn(weakPullupEn), .normPullupEn(normPullupEn), .highSideEn(highSideEn), .wakeEvent(wakeEvent));

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import lintc_pkg::*;
  logic clk_sys = 0, srst = 1, txData = 1, chipNormal = 1, supplyLow = 0, overTemp = 0, lpRegOn = 1, domReq = 0;
  logic rxData, busIn, busOut, busOe_n, weakPullupEn, normPullupEn, highSideEn, wakeEvent, wakeIrq;
  logic [1:0] slopeSel;
  logic lpRegOff = 0, regRestart;
  lintc_cmd_type cmd = '0;
  lintc_stat_type stat;
  int miscompares = 0, check_count = 0;
  always #4 clk_sys = !clk_sys;
  lintc_channel #(.TXDOM_CYC(50)) u_lintc_channel (.clk_sys(clk_sys), .srst(srst), .txData(txData),
    .rxData(rxData), .busIn(busIn), .busOut(busOut), .busOe_n(busOe_n), .cmd(cmd), .chipNormal(chipNormal),
    .supplyLow(supplyLow), .overTemp(overTemp), .lpRegOn(lpRegOn), .lpRegOff(lpRegOff), .stat(stat),
    .weakPullupEn(weakPullupEn), .normPullupEn(normPullupEn), .highSideEn(highSideEn), .slopeSel(slopeSel),
    .wakeEvent(wakeEvent), .wakeIrq(wakeIrq), .regRestart(regRestart));
  lintc_bus_model u_lintc_bus_model (.busOut(busOut), .busOe_n(busOe_n), .domReq(domReq), .busIn(busIn));
  // ==========================================
  // helpers
  task automatic chk(input logic g, input logic e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got %b exp %b", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic send(input logic [1:0] m, input logic [1:0] b, input logic w);
    @(negedge clk_sys);
    cmd = '{1'b1, m, b, w};
    @(negedge clk_sys);
    cmd.cmdValid = 1'b0;
    cyc(3);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_txrx;
    for (int b = 0; b < 3; b++) begin
      send(2'h1, 2'(b), 1'b0);
      chk(slopeSel === 2'(b), 1'b1);
      chk(stat.baudNow === 2'(b), 1'b1);
    end
    chk(stat.modeNow === 2'h1, 1'b1);
    txData = 0;
    cyc(4);
    chk(busOe_n, 1'b0);
    chk(busOut, 1'b0);
    chk(rxData, 1'b0);
    txData = 1;
    cyc(4);
    chk(rxData, 1'b1);
    txData = 0;
    cyc(60);
    chk(busOe_n, 1'b1);
    chk(stat.timeoutFlag, 1'b1);
    txData = 1;
    cyc(2);
    txData = 0;
    cyc(3);
    chk(busOe_n, 1'b0);
    $display("txrx and timeout done");
  endtask
  task automatic t_faults;
    supplyLow = 1;
    cyc(3);
    chk(busOe_n, 1'b1);
    supplyLow = 0;
    overTemp = 1;
    cyc(3);
    chk(busOe_n, 1'b1);
    chk(highSideEn, 1'b0);
    overTemp = 0;
    chipNormal = 0;
    cyc(3);
    chk(busOe_n, 1'b1);
    chipNormal = 1;
    send(2'h0, 2'h0, 1'b0);
    send(2'h1, 2'h0, 1'b0);
    chk(stat.modeNow === 2'h0, 1'b1);
    txData = 1;
    $display("faults and refusal done");
  endtask
  task automatic t_wake(input logic en, input int len, input logic e);
    logic seen, irq, rst;
    send(2'h2, 2'h0, en);
    chk(weakPullupEn & !normPullupEn, 1'b1);
    domReq = 1;
    cyc(len);
    domReq = 0;
    seen = 0;
    irq = 0;
    rst = 0;
    repeat (8) begin
      @(negedge clk_sys);
      seen |= wakeEvent;
      irq |= wakeIrq;
      rst |= regRestart;
    end
    chk(seen, e);
    chk(irq, e && lpRegOn);
    chk(rst, e && lpRegOff);
    chk(stat.wakeFlag, e);
    $display("wake case done");
  endtask
  initial begin
    cyc(4);
    srst = 0;
    t_txrx();
    t_faults();
    t_wake(1'b1, 8800, 1'b1);
    t_wake(1'b1, 8600, 1'b0);
    t_wake(1'b0, 8800, 1'b0);
    lpRegOn = 0;
    lpRegOff = 1;
    t_wake(1'b1, 8800, 1'b1);
    final_report();
  end
endmodule // testbench
